// ### rtl/spm_consts.vh
/*
 Constants for the shared pin function selector: pullup register layout,
 reset values and synchroniser depth. Assumes inclusion by bare name.
*/
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// Pullup enable register, address and field positions
`define SPM_PUE_ADDR     16'h000B
`define SPM_PUE_OSC_OUTPUT_ENABLE   7
`define SPM_PUE_LINE_LSB 0
`define SPM_PUE_LINE_MSB 5
`define SPM_PUE_RESET    8'h00
`define SPM_PTB_PUE_RST  8'h00
// Port widths
`define SPM_PTA_W        6
`define SPM_PTB_W        8
// Synchroniser depth for pin inputs
`define SPM_SYNC_DEPTH   3
// Per line function select codes
`define SPM_SEL_GPIO     2'h0
`define SPM_SEL_LOW      2'h1
`define SPM_SEL_MID      2'h2
`define SPM_SEL_TOP      2'h3

`endif

// ### rtl/spm_pin_mux.v
/*
 Shared pin function selector for a six line port A and an eight line port B.
 Picks, per pin, the highest priority enabled function and routes pad driver,
 output enable, pullup and sampled input to it alone.
 Assumes the enables come from logic on sys_clk; pads are sampled here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spm_consts.vh"

module spm_pin_mux #(
	parameter PTA_W = `SPM_PTA_W,
	parameter PTB_W = `SPM_PTB_W
) (
	input  wire             sys_clk,          // Bus clock, 50 MHz
	input  wire             rst,              // Async reset, active high
	input  wire             clk_en,           // Freezes all state when low
	input  wire             pue_wr,           // Write strobe, pullup register
	input  wire [7:0]       pue_wdata,        // Pullup register write data
	output reg  [7:0]       pue_rdata,        // Pullup register contents
	input  wire             ptb_pue_wr,       // Write strobe, port B pullups
	input  wire [PTB_W-1:0] ptb_pue_wdata,    // Port B pullup write data
	input  wire             ptb_present,      // Larger package, port B bonded
	input  wire             adc_en0,          // Analog channel zero enabled
	input  wire             adc_en1,          // Analog channel one enabled
	input  wire             adc_en2,          // Analog channel two enabled
	input  wire             adc_en3,          // Analog channel three enabled
	input  wire             tim_en0,          // Timer channel zero owns pin
	input  wire             tim_en1,          // Timer channel one owns pin
	input  wire             tim_out0,         // Timer channel zero output
	input  wire             tim_out1,         // Timer channel one output
	input  wire             tim_oe0,          // Timer channel zero drives
	input  wire             tim_oe1,          // Timer channel one drives
	input  wire             timer_clock_pin_en,          // Timer clock from line two
	input  wire [PTA_W-1:0] kbd_en,           // Keyboard input enables
	input  wire             irq_en,           // External interrupt enabled
	input  wire             irq_pud,          // Interrupt pullup disable
	input  wire             rst_pin_en,       // Line three is reset input
	input  wire             xtal_opt,         // Crystal oscillator option
	input  wire             osc_in_en,        // Line five is oscillator in
	input  wire             osc_clk,          // RC or internal oscillator clock
	input  wire             xtal_drive,       // Crystal amplifier output
	input  wire [PTA_W-1:0] pta_dout,         // Port A data register
	input  wire [PTA_W-1:0] pta_ddr,          // Port A direction, 1 = out
	input  wire [PTB_W-1:0] ptb_dout,         // Port B data register
	input  wire [PTB_W-1:0] ptb_ddr,          // Port B direction, 1 = out
	input  wire [PTA_W-1:0] pta_pad_in,       // Port A pad input
	output reg  [PTA_W-1:0] pta_pad_out,      // Port A pad output
	output reg  [PTA_W-1:0] pta_pad_oe,       // Port A pad enable, high drives
	output reg  [PTA_W-1:0] pta_pullup,       // Port A pullup on
	output reg  [PTA_W-1:0] pta_schmitt,      // Port A hysteresis select
	input  wire [PTB_W-1:0] ptb_pad_in,       // Port B pad input
	output reg  [PTB_W-1:0] ptb_pad_out,      // Port B pad output
	output reg  [PTB_W-1:0] ptb_pad_oe,       // Port B pad enable
	output reg  [PTB_W-1:0] ptb_pullup,       // Port B pullup on
	output reg  [PTA_W-1:0] pta_gpio_in,      // Port A general input
	output reg  [PTB_W-1:0] ptb_gpio_in,      // Port B general input
	output reg  [PTA_W-1:0] kbd_in,           // Keyboard inputs, wake capable
	output reg  [3:0]       adc_in_sel,       // Analog channels granted
	output reg              tim_in0,          // Timer channel zero input
	output reg              tim_in1,          // Timer channel one input
	output reg              timer_clock_pin_in,          // Timer clock input
	output reg              irq_in_n,         // External interrupt, active low
	output reg              rst_in_n,         // Reset pin level, active low
	output reg              osc_in            // Oscillator input from pad
);

	// ******************************************
	// Selection function
	// ******************************************
	// Priority encode three enables, top first.
	function [1:0] spm_pick;
		input top, mid, low;
		spm_pick = top ? `SPM_SEL_TOP : mid ? `SPM_SEL_MID
			: low ? `SPM_SEL_LOW : `SPM_SEL_GPIO;
	endfunction

	// ******************************************
	// Registers
	// ******************************************
	reg [7:0]       pue_q;
	reg [PTB_W-1:0] ptb_pue_q;
	reg             live_q;
	reg [PTA_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_q;
	reg [PTB_W-1:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_q;

	// Alternate functions held off until the first enabled edge after reset.
	// Pullup register reset
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pue_q     <= `SPM_PUE_RESET;
			ptb_pue_q <= `SPM_PTB_PUE_RST;
			live_q    <= 1'b0;
		end else if (clk_en) begin
			live_q <= 1'b1;
			if (pue_wr)
				pue_q <= {pue_wdata[7], 1'b0, pue_wdata[5:0]};
			if (ptb_pue_wr)
				ptb_pue_q <= ptb_pue_wdata;
		end
	end

	// Three stage sampling; a change counts when stages two and three agree.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{pa_s1_q, pa_s2_q, pa_s3_q, pa_q} <= {4*PTA_W{1'b1}};
			{pb_s1_q, pb_s2_q, pb_s3_q, pb_q} <= {4*PTB_W{1'b0}};
		end else if (clk_en) begin
			{pa_s3_q, pa_s2_q, pa_s1_q} <= {pa_s2_q, pa_s1_q, pta_pad_in};
			pa_q    <= (pa_s2_q & pa_s3_q) | (pa_q & (pa_s2_q ^ pa_s3_q));
			{pb_s3_q, pb_s2_q, pb_s1_q} <= {pb_s2_q, pb_s1_q, ptb_pad_in};
			pb_q    <= (pb_s2_q & pb_s3_q) | (pb_q & (pb_s2_q ^ pb_s3_q));
		end
	end

	// ******************************************
	// Per line arbitration
	// ******************************************
	reg [1:0] sel0, sel1, sel2, sel3, sel4, sel5;
	integer   i;

	always @* begin
		sel0 = live_q ? spm_pick(adc_en0, tim_en0, kbd_en[0]) : `SPM_SEL_GPIO;
		sel1 = live_q ? spm_pick(adc_en1, tim_en1, kbd_en[1]) : `SPM_SEL_GPIO;
		sel2 = live_q ? spm_pick(irq_en, kbd_en[2], timer_clock_pin_en) : `SPM_SEL_GPIO;
		sel3 = live_q ? spm_pick(rst_pin_en, kbd_en[3], 1'b0) : `SPM_SEL_GPIO;
		sel4 = live_q ? spm_pick(pue_q[`SPM_PUE_OSC_OUTPUT_ENABLE] | xtal_opt, adc_en2, kbd_en[4])
			: `SPM_SEL_GPIO;
		sel5 = live_q ? spm_pick(osc_in_en, adc_en3, kbd_en[5]) : `SPM_SEL_GPIO;
	end

	always @* begin
		pta_pad_out = {PTA_W{1'b0}};
		pta_pad_oe  = {PTA_W{1'b0}};
		pta_schmitt = {PTA_W{1'b0}};
		pta_pullup  = pue_q[`SPM_PUE_LINE_MSB:`SPM_PUE_LINE_LSB];
		pta_gpio_in = {PTA_W{1'b0}};
		kbd_in      = {PTA_W{1'b1}};
		adc_in_sel  = 4'h0;
		tim_in0     = 1'b0;
		tim_in1     = 1'b0;
		timer_clock_pin_in     = 1'b0;
		irq_in_n    = 1'b1;
		rst_in_n    = 1'b1;
		osc_in      = 1'b0;
		case (sel0)
			`SPM_SEL_TOP: begin
				adc_in_sel[0]  = 1'b1;
				pta_pullup[0]  = 1'b0;
			end
			`SPM_SEL_MID: begin
				pta_pad_out[0] = tim_out0;
				pta_pad_oe[0]  = tim_oe0;
				tim_in0        = pa_q[0];
			end
			`SPM_SEL_LOW: kbd_in[0] = pa_q[0];
			default: begin
				pta_pad_out[0] = pta_dout[0];
				pta_pad_oe[0]  = pta_ddr[0];
				pta_gpio_in[0] = pa_q[0];
			end
		endcase
		case (sel1)
			`SPM_SEL_TOP: begin
				adc_in_sel[1]  = 1'b1;
				pta_pullup[1]  = 1'b0;
			end
			`SPM_SEL_MID: begin
				pta_pad_out[1] = tim_out1;
				pta_pad_oe[1]  = tim_oe1;
				tim_in1        = pa_q[1];
			end
			`SPM_SEL_LOW: kbd_in[1] = pa_q[1];
			default: begin
				pta_pad_out[1] = pta_dout[1];
				pta_pad_oe[1]  = pta_ddr[1];
				pta_gpio_in[1] = pa_q[1];
			end
		endcase
		case (sel2)
			`SPM_SEL_TOP: begin
				irq_in_n       = pa_q[2];
				pta_schmitt[2] = 1'b1;
				pta_pullup[2]  = ~irq_pud;
			end
			`SPM_SEL_MID: kbd_in[2] = pa_q[2];
			`SPM_SEL_LOW: timer_clock_pin_in = pa_q[2];
			default: pta_gpio_in[2] = pa_q[2];
		endcase
		case (sel3)
			`SPM_SEL_TOP: begin
				rst_in_n       = pa_q[3];
				pta_pullup[3]  = 1'b1;
				pta_schmitt[3] = 1'b1;
			end
			`SPM_SEL_MID: kbd_in[3] = pa_q[3];
			default: begin
				pta_pad_out[3] = pta_dout[3];
				pta_pad_oe[3]  = pta_ddr[3];
				pta_gpio_in[3] = pa_q[3];
			end
		endcase
		case (sel4)
			`SPM_SEL_TOP: begin
				pta_pad_out[4] = xtal_opt ? xtal_drive : osc_clk;
				pta_pad_oe[4]  = 1'b1;
				pta_pullup[4]  = 1'b0;
			end
			`SPM_SEL_MID: begin
				adc_in_sel[2]  = 1'b1;
				pta_pullup[4]  = 1'b0;
			end
			`SPM_SEL_LOW: kbd_in[4] = pa_q[4];
			default: begin
				pta_pad_out[4] = pta_dout[4];
				pta_pad_oe[4]  = pta_ddr[4];
				pta_gpio_in[4] = pa_q[4];
			end
		endcase
		case (sel5)
			`SPM_SEL_TOP: begin
				osc_in         = pa_q[5];
				pta_pullup[5]  = 1'b0;
			end
			`SPM_SEL_MID: begin
				adc_in_sel[3]  = 1'b1;
				pta_pullup[5]  = 1'b0;
			end
			`SPM_SEL_LOW: kbd_in[5] = pa_q[5];
			default: begin
				pta_pad_out[5] = pta_dout[5];
				pta_pad_oe[5]  = pta_ddr[5];
				pta_gpio_in[5] = pa_q[5];
			end
		endcase
		// Pullup never fights an active driver
		for (i = 0; i < PTA_W; i = i + 1) begin
			if (pta_pad_oe[i])
				pta_pullup[i] = 1'b0;
		end
		if (!live_q)
			pta_pad_oe = {PTA_W{1'b0}};
		pue_rdata = pue_q;
	end

	// ******************************************
	// Port B
	// ******************************************
	// Eight lines when bonded
	always @* begin
		if (ptb_present && live_q) begin
			ptb_pad_oe  = ptb_ddr;
			ptb_pullup  = ptb_pue_q & ~ptb_ddr;
		end else begin
			ptb_pad_oe  = {PTB_W{1'b0}};
			ptb_pullup  = {PTB_W{1'b0}};
		end
		ptb_pad_out = ptb_dout;
		ptb_gpio_in = ptb_present ? pb_q : {PTB_W{1'b0}};
	end

endmodule

`default_nettype wire

// ### verif/spm_board.sv
/* Board model for one port of the pin selector.
 Assumes the device pad outputs and one bench level per pin. */
`timescale 1ns/100ps
`default_nettype none
module spm_board #(
	parameter int W = 6
) (
	input  wire logic [W-1:0] pad_out, // Device drive level
	input  wire logic [W-1:0] pad_oe,  // Device drives pin
	input  wire logic [W-1:0] pull,    // Device pullup on
	input  wire logic [W-1:0] ext,     // Board level
	input  wire logic [W-1:0] ext_en,  // Board drives pin
	output logic [W-1:0]      pad_in   // Resulting pin level
);
	// Floating pins without pullup read low, never a stale level
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext) | (~pad_oe & ~ext_en & pull);
endmodule
`default_nettype wire

// ### verif/spm_pin_mux_chk.sv
/* Port checker for spm_pin_mux.
 Assumes a bind to spm_pin_mux and one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module spm_pin_mux_chk #(
	parameter PTA_W = 6,
	parameter PTB_W = 8
) (
	input wire logic             sys_clk,     // Clock
	input wire logic             rst,         // Reset
	input wire logic             clk_en,      // Clock enable
	input wire logic             pue_wr,      // Pullup write
	input wire logic [7:0]       pue_wdata,   // Pullup data
	input wire logic [7:0]       pue_rdata,   // Pullup register
	input wire logic             ptb_present, // Port B bonded
	input wire logic             adc_en0,     // Analog zero
	input wire logic             adc_en1,     // Analog one
	input wire logic             tim_en0,     // Timer zero
	input wire logic             tim_en1,     // Timer one
	input wire logic             tim_oe0,     // Timer zero drives
	input wire logic             tim_out0,    // Timer zero level
	input wire logic             irq_en,      // Interrupt role
	input wire logic             irq_pud,     // Interrupt pullup off
	input wire logic             rst_pin_en,  // Reset role
	input wire logic             xtal_opt,    // Crystal option
	input wire logic             osc_clk,     // Internal clock
	input wire logic [PTA_W-1:0] pta_ddr,     // Port A direction
	input wire logic [PTA_W-1:0] pta_pad_out, // Port A out
	input wire logic [PTA_W-1:0] pta_pad_oe,  // Port A enable
	input wire logic [PTA_W-1:0] pta_pullup,  // Port A pullup
	input wire logic [PTA_W-1:0] pta_schmitt, // Port A hysteresis
	input wire logic [PTB_W-1:0] ptb_ddr,     // Port B direction
	input wire logic [PTB_W-1:0] ptb_pad_oe   // Port B enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic live_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) live_q <= 1'b0;
		else if (clk_en) live_q <= 1'b1;
	end
	a_reset_all_in: assert property (!live_q |-> pta_pad_oe == 0 && ptb_pad_oe == 0)
		else $error("pin driven before release");
	a_line2_in_only: assert property (pta_pad_oe[2] == 1'b0)
		else $error("line two driven");
	a_tim0_drives: assert property (live_q && !adc_en0 && tim_en0 && tim_oe0
		|-> pta_pad_oe[0] && pta_pad_out[0] == tim_out0) else $error("timer zero lost pin");
	a_rst_role: assert property (live_q && rst_pin_en
		|-> pta_pullup[3] && pta_schmitt[3] && !pta_pad_oe[3]) else $error("reset role wrong");
	a_irq_pullup: assert property (live_q && irq_en
		|-> pta_pullup[2] == !irq_pud && pta_schmitt[2]) else $error("interrupt pullup wrong");
	a_osc_out: assert property (live_q && pue_rdata[7] && !xtal_opt
		|-> pta_pad_oe[4] && pta_pad_out[4] == osc_clk) else $error("clock out missing");
	a_pue_write: assert property (pue_wr && clk_en |=> pue_rdata == ($past(pue_wdata) & 8'hBF))
		else $error("pullup write wrong");
	a_pue_holds: assert property (!(pue_wr && clk_en) |=> $stable(pue_rdata))
		else $error("pullup register moved");
	a_pullup_bit: assert property (live_q && pue_rdata[1] && !adc_en1 && !tim_en1 && !pta_ddr[1]
		|-> pta_pullup[1]) else $error("line one pullup off");
	a_portb_dir: assert property (live_q |-> ptb_pad_oe == (ptb_present ? ptb_ddr : 8'h00))
		else $error("port B enable wrong");
endmodule
bind spm_pin_mux spm_pin_mux_chk #(.PTA_W(PTA_W), .PTB_W(PTB_W)) i_spm_pin_mux_chk (.*);
`default_nettype wire

// ### verif/test_spm_pin_mux.sv
/* Self-checking bench for spm_pin_mux.
 Assumes spm_board for pads and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_spm_pin_mux;
	logic sys_clk, rst, clk_en, pue_wr, ptb_pue_wr, ptb_present, timer_clock_pin_en, irq_en, irq_pud;
	logic adc_en0, adc_en1, adc_en2, adc_en3, tim_en0, tim_en1, tim_out0, tim_out1, tim_oe0;
	logic tim_oe1, rst_pin_en, xtal_opt, osc_in_en, osc_clk, xtal_drive;
	logic [7:0] pue_wdata, ptb_pue_wdata, ptb_dout, ptb_ddr, ext_b, ext_b_en;
	logic [5:0] kbd_en, pta_dout, pta_ddr, ext_a, ext_a_en;
	wire  [7:0] pue_rdata, ptb_pad_in, ptb_pad_out, ptb_pad_oe, ptb_pullup, ptb_gpio_in;
	wire  [5:0] pta_pad_in, pta_pad_out, pta_pad_oe, pta_pullup, pta_schmitt, pta_gpio_in, kbd_in;
	wire  [3:0] adc_in_sel;
	wire        tim_in0, tim_in1, timer_clock_pin_in, irq_in_n, rst_in_n, osc_in;
	int         n_mismatch, n_tests, i;
	spm_pin_mux i_spm_pin_mux (.*);
	spm_board #(.W(6)) i_spm_board_a (.pad_out(pta_pad_out), .pad_oe(pta_pad_oe),
		.pull(pta_pullup), .ext(ext_a), .ext_en(ext_a_en), .pad_in(pta_pad_in));
	spm_board #(.W(8)) i_spm_board_b (.pad_out(ptb_pad_out), .pad_oe(ptb_pad_oe),
		.pull(ptb_pullup), .ext(ext_b), .ext_en(ext_b_en), .pad_in(ptb_pad_in));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Pullup register write, one strobe cycle
	task automatic wr_pue(input logic [7:0] d);
		pue_wr = 1'b1;
		pue_wdata = d;
		cyc(1);
		pue_wr = 1'b0;
		cyc(1);
	endtask
	initial begin
		{pue_wr, ptb_pue_wr, timer_clock_pin_en, irq_en, irq_pud, adc_en0, adc_en1, adc_en2, adc_en3} = '0;
		{tim_en0, tim_en1, tim_out0, tim_out1, tim_oe0, tim_oe1, rst_pin_en, xtal_opt} = '0;
		{osc_in_en, osc_clk, xtal_drive, pue_wdata, ptb_pue_wdata, ptb_dout, ext_b} = '0;
		{kbd_en, pta_dout, ext_a, ext_a_en, ext_b_en} = '0;
		{pta_ddr, ptb_ddr, rst, clk_en, ptb_present} = '1;
		cyc(20);
		rst = 1'b0;
		#1;
		chk("oe_a", pta_pad_oe, 8'h00);
		chk("oe_b", ptb_pad_oe, 8'h00);
		chk("pue", pue_rdata, 8'h00);
		cyc(1);
		chk("oe_a", pta_pad_oe, 8'h3B);
		chk("oe_b", ptb_pad_oe, 8'hFF);
		{tim_oe0, tim_oe1, tim_out0, tim_out1, osc_clk} = '1;
		for (i = 0; i < 8; i++) begin
			{adc_en0, tim_en0, kbd_en[0]} = i[2:0];
			{adc_en1, tim_en1, kbd_en[1]} = i[2:0];
			cyc(1);
			chk("oe01", pta_pad_oe[1:0], {2{!i[2] && (i[1] || !i[0])}});
			chk("out01", pta_pad_out[1:0] & pta_pad_oe[1:0], {2{!i[2] && i[1]}});
			chk("adc01", adc_in_sel[1:0], {2{i[2]}});
		end
		for (i = 0; i < 16; i++) begin
			{xtal_opt, adc_en2, adc_en3, osc_in_en} = {i[2], i[1], i[1], i[0]};
			wr_pue({i[3], 7'h7F});
			chk("pue", pue_rdata, {i[3], 7'h3F});
			chk("oe4", pta_pad_oe[4], (i[3] | i[2]) | !i[1]);
			chk("out4", pta_pad_out[4] & pta_pad_oe[4], (i[3] | i[2]) & !i[2]);
			chk("oe5", pta_pad_oe[5], !i[0] & !i[1]);
			chk("adc23", adc_in_sel[3:2], {!i[0] & i[1], !(i[3] | i[2]) & i[1]});
		end
		{adc_en0, adc_en1, adc_en2, adc_en3, tim_en0, tim_en1, xtal_opt, osc_in_en} = '0;
		wr_pue(8'h3F);
		{pta_ddr, ext_a_en, kbd_en, irq_en, rst_pin_en} = {6'h00, 6'h3F, 6'h3F, 2'b11};
		cyc(6);
		chk("irq", irq_in_n, 8'h00);
		chk("rst_in", rst_in_n, 8'h00);
		chk("kbd", kbd_in, 8'h0C);
		chk("pull", pta_pullup, 8'h3F);
		chk("hyst", pta_schmitt[3:2], 8'h03);
		{irq_en, rst_pin_en, ext_a} = {2'b00, 6'h2A};
		cyc(6);
		chk("kbd", kbd_in, 8'h2A);
		chk("irq", irq_in_n, 8'h01);
		{kbd_en, timer_clock_pin_en, ext_a, pta_ddr} = {6'h00, 1'b1, 6'h24, 6'h01};
		cyc(6);
		chk("timer_clock_pin", timer_clock_pin_in, 8'h01);
		chk("pull", pta_pullup, 8'h3E);
		chk("gpio_a", pta_gpio_in, 8'h20);
		{tim_en0, tim_en1, osc_in_en} = 3'b111;
		cyc(6);
		chk("tim0", tim_in0, 8'h01);
		chk("tim1", tim_in1, 8'h01);
		chk("osc_in", osc_in, 8'h01);
		chk("gpio_a", pta_gpio_in, 8'h00);
		chk("pull", pta_pullup, 8'h1C);
		{ptb_ddr, ptb_dout, ext_b, ext_b_en, ptb_pue_wdata, ptb_pue_wr} = {40'hF0A50C0F03, 1'b1};
		cyc(1);
		ptb_pue_wr = 1'b0;
		cyc(6);
		chk("pull_b", ptb_pullup, 8'h03);
		chk("gpio_b", ptb_gpio_in, 8'hAC);
		chk("out_b", ptb_pad_out, 8'hA5);
		ptb_present = 1'b0;
		cyc(6);
		chk("oe_b", ptb_pad_oe, 8'h00);
		chk("gpio_b", ptb_gpio_in, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
